// ---- core/asc_defs.svh ----
// Constants of the serial configuration block: frame timing, word layout, codes.
// Assumes inclusion by bare name from every file that needs a figure.
`ifndef ASC_DEFS_SVH
`define ASC_DEFS_SVH

// Frame and word geometry
`define ASC_CFG_W        12
`define ASC_FRAME_LEN    16
`define ASC_CFG_EDGES    12
`define ASC_MUX_EDGE     14
`define ASC_CNT_W        5
`define ASC_RES_W        12

// Bit positions inside the incoming word
`define ASC_BIT_WRITE    11
`define ASC_BIT_SWEEP_HI 10
`define ASC_BIT_CHAN_HI  7
`define ASC_BIT_CHAN_LO  6
`define ASC_BIT_PM_HI    5
`define ASC_BIT_PM_LO    4
`define ASC_BIT_SWEEP_LO 3
`define ASC_BIT_RANGE    1
`define ASC_BIT_CODING   0

// Power mode and sweep codes
`define ASC_PM_NORMAL    2'h3
`define ASC_PM_FULL      2'h2
`define ASC_PM_AUTO      2'h1
`define ASC_SWEEP_CONT   2'h3

// Stored configuration after reset: normal power, channel 0
`define ASC_CFG_RESET    8'h18

// Wake-up time and system clock period
`define ASC_CLK_NS       50
`define ASC_WAKE_NS      1000
`define ASC_WAKE_CYC     ((`ASC_WAKE_NS + `ASC_CLK_NS - 1) / `ASC_CLK_NS)

`endif

// ---- core/asc_pkg.sv ----
// Types shared by the serial configuration block.
// Assumes nothing beyond a SystemVerilog compiler.
package asc_pkg;

    // Stored configuration, unused bits dropped
    typedef struct packed {
        logic sweep_ctrl_hi;
        logic chan_sel_hi;
        logic chan_sel_lo;
        logic power_mode_hi;
        logic power_mode_lo;
        logic sweep_ctrl_lo;
        logic range_sel;
        logic coding;
    } asc_cfg_t;

    // Result with its channel tag
    typedef struct packed {
        logic [1:0]  chan;
        logic [11:0] data;
    } asc_result_t;

    // Settings handed to the conversion core
    typedef struct packed {
        logic [1:0] chan;
        logic       range_sel;
        logic       coding;
    } asc_conv_t;

    typedef enum logic [1:0] {st_idle, st_conv, st_down} asc_state_t;

endpackage : asc_pkg

// ---- core/asc_sync.sv ----
// Two-flop level synchroniser, one chain per bit.
// Assumes each input bit is a level or toggle from another clock domain.
`timescale 1ns/1ps
`default_nettype none
module asc_sync #(
    parameter int W = 4
) (
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    generate
        if (W < 1) begin : g_chk
            $error("asc_sync needs at least one bit");
        end
        for (genvar i = 0; i < W; i++) begin : g_bit
            // First flop feeds only the second
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    meta[i] <= 1'b0;
                    q[i]    <= 1'b0;
                end else begin
                    meta[i] <= d[i];
                    q[i]    <= meta[i];
                end
            end
        end
    endgenerate
endmodule : asc_sync
`default_nettype wire

// ---- core/asc_link.sv ----
// Serial-clock side: shifts the word in, the previous result out.
// Assumes sclk stands still outside frames; falling edges do all work.
`timescale 1ns/1ps
`default_nettype none
`include "asc_defs.svh"
module asc_link (
    input  wire logic               sclk,
    input  wire logic               reset_n,
    input  wire logic               cs_n,
    input  wire logic               din,
    input  wire asc_pkg::asc_result_t result_word,
    output logic                    dout,
    output asc_pkg::asc_cfg_t       cfg_hold,
    output logic                    cfg_tgl,
    output logic                    mux_tgl,
    output logic                    eoc_tgl
);
    import asc_pkg::*;

    logic [`ASC_CNT_W-1:0]     cnt, next_cnt;
    logic [`ASC_CFG_W-2:0]     in_sreg, next_in_sreg;
    logic [`ASC_FRAME_LEN-3:0] out_sreg, next_out_sreg;
    logic [`ASC_CFG_W-1:0]     word;
    logic [`ASC_FRAME_LEN-1:0] out_word;
    logic                      next_dout, next_cfg_tgl, next_mux_tgl, next_eoc_tgl;
    asc_cfg_t                  next_cfg_hold;
    logic                      frame_rst_n;

    // Chip select high holds the frame logic cleared
    assign frame_rst_n = reset_n & ~cs_n;

    // Next values for one falling edge
    always_comb begin
        word          = {in_sreg, din};
        out_word      = {2'h0, result_word};
        next_cnt      = cnt;
        next_in_sreg  = in_sreg;
        next_cfg_hold = cfg_hold;
        next_cfg_tgl  = cfg_tgl;
        next_mux_tgl  = mux_tgl;
        next_eoc_tgl  = eoc_tgl;
        if (cnt < `ASC_CNT_W'(`ASC_FRAME_LEN)) begin
            next_cnt = cnt + `ASC_CNT_W'(1);
        end
        // First bit sent is the top bit of the word
        if (cnt < `ASC_CNT_W'(`ASC_CFG_EDGES - 1)) begin
            next_in_sreg = word[`ASC_CFG_W-2:0];
        end
        // Twelfth edge closes the word; later edges never touch it
        if (cnt == `ASC_CNT_W'(`ASC_CFG_EDGES - 1) && word[`ASC_BIT_WRITE]) begin
            next_cfg_hold = {word[`ASC_BIT_SWEEP_HI], word[`ASC_BIT_CHAN_HI], word[`ASC_BIT_CHAN_LO],
                             word[`ASC_BIT_PM_HI], word[`ASC_BIT_PM_LO], word[`ASC_BIT_SWEEP_LO],
                             word[`ASC_BIT_RANGE], word[`ASC_BIT_CODING]};
            next_cfg_tgl  = ~cfg_tgl;
        end
        if (cnt == `ASC_CNT_W'(`ASC_MUX_EDGE - 1)) begin
            next_mux_tgl = ~mux_tgl;
        end
        if (cnt == `ASC_CNT_W'(`ASC_FRAME_LEN - 1)) begin
            next_eoc_tgl = ~eoc_tgl;
        end
        // Result word is read only inside a frame, when the core keeps it still
        if (cnt == `ASC_CNT_W'(0)) begin
            next_dout     = out_word[`ASC_FRAME_LEN-2];
            next_out_sreg = out_word[`ASC_FRAME_LEN-3:0];
        end else begin
            next_dout     = out_sreg[`ASC_FRAME_LEN-3];
            next_out_sreg = {out_sreg[`ASC_FRAME_LEN-4:0], 1'b0};
        end
    end

    // Frame state, cleared whenever chip select is high
    always_ff @(negedge sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            cnt      <= '0;
            in_sreg  <= '0;
            out_sreg <= '0;
            dout     <= 1'b0;
        end else begin
            cnt      <= next_cnt;
            in_sreg  <= next_in_sreg;
            out_sreg <= next_out_sreg;
            dout     <= next_dout;
        end
    end

    // Toggles and held word survive between frames
    always_ff @(negedge sclk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_hold <= `ASC_CFG_RESET;
            cfg_tgl  <= 1'b0;
            mux_tgl  <= 1'b0;
            eoc_tgl  <= 1'b0;
        end else begin
            cfg_hold <= next_cfg_hold;
            cfg_tgl  <= next_cfg_tgl;
            mux_tgl  <= next_mux_tgl;
            eoc_tgl  <= next_eoc_tgl;
        end
    end
endmodule : asc_link
`default_nettype wire

// ---- core/asc_top.sv ----
// Serial configuration and channel/power control of a four-input converter.
// Assumes the conversion core on clk holds conv_data valid at end of frame.
// Assumes sclk stands still between frames and the host spaces its frames,
// so the link's held word and this side's result stay quiet while read.
//
// Overview of operation
// - Twelve-bit write-only word, captured on falling edges
// - Every frame spans sixteen serial clocks
// - Only first twelve edges load the word
// - New settings apply to the next conversion
// - Fixed field order from write-enable to coding
// - Write-enable low leaves stored word unchanged
// - Two sweep bits together pick sequencer mode
// - Channel bits take effect on the fourteenth falling edge
// - Channel pair decodes as plain binary
// - Result carries its channel address first
// - Input mux switches on fourteenth falling edge
// - Power code high-high keeps full power
// - Code high-low powers down until rewritten
// - Code low-high shuts down after conversions in frames that write the word
// - Range bit picks span for next conversion
// - Coding bit picks result format next conversion
// - Output: two zeros, address, twelve data bits
// - Sweep codes: none, continue, consecutive sweep
`timescale 1ns/1ps
`default_nettype none
`include "asc_defs.svh"
module asc_top #(
    parameter int WAKE_CYC = `ASC_WAKE_CYC
) (
    input  wire logic                    clk,
    input  wire logic                    reset_n,
    input  wire logic                    sclk,
    input  wire logic                    cs_n,
    input  wire logic                    din,
    input  wire logic [`ASC_RES_W-1:0]   conv_data,
    output logic                         dout,
    output logic                         conv_start,
    output asc_pkg::asc_conv_t           conv_set,
    output logic [1:0]                   mux_chan,
    output logic                         power_down,
    output logic                         awake
);
    import asc_pkg::*;

    localparam int WCW = $clog2(WAKE_CYC + 1);

    // Parameter check
    generate
        if (WAKE_CYC < 1) begin : g_chk
            $error("asc_top: WAKE_CYC must be at least one cycle");
        end
    endgenerate

    // Link-side signals
    asc_cfg_t    cfg_hold;
    logic        cfg_tgl;
    logic        mux_tgl;
    logic        eoc_tgl;
    asc_result_t result_word, next_result_word;

    // Synchronised copies and their delayed versions
    logic [3:0]  sync_q;
    logic [3:0]  sync_d, next_sync_d;
    logic        cs_fall, cfg_ev, mux_ev, eoc_ev;

    // Control state
    asc_cfg_t    cfg, next_cfg;
    asc_state_t  state, next_state;
    logic        wr_seen, next_wr_seen;
    logic        sweep_on, next_sweep_on;
    logic        sweep_start, next_sweep_start;
    logic [1:0]  sweep_last, next_sweep_last;
    logic [1:0]  next_mux_chan;
    asc_conv_t   next_conv_set;
    logic        next_conv_start, next_power_down, next_awake;
    logic [WCW-1:0] wake_cnt, next_wake_cnt;
    logic [1:0]  pm, new_pm;
    logic [1:0]  sweep_code;
    logic        new_full, new_auto, new_normal;
    asc_conv_t   frozen_set;
    logic [`ASC_RES_W-1:0] coded_data;

    // Serial-clock side of the frame
    asc_link u_link (
        .sclk        (sclk),
        .reset_n     (reset_n),
        .cs_n        (cs_n),
        .din         (din),
        .result_word (result_word),
        .dout        (dout),
        .cfg_hold    (cfg_hold),
        .cfg_tgl     (cfg_tgl),
        .mux_tgl     (mux_tgl),
        .eoc_tgl     (eoc_tgl)
    );

    // Chip select as a level, three events as toggles
    // Only one-bit signals cross through the synchroniser; the wide held word is read after its toggle,
    // when the link has kept it still for many clk cycles
    asc_sync #(
        .W (4)
    ) u_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .d       ({cs_n, eoc_tgl, mux_tgl, cfg_tgl}),
        .q       (sync_q)
    );

    // Event decode from synchronised and delayed copies
    assign next_sync_d = sync_q;
    assign cs_fall     = sync_d[3] & ~sync_q[3];
    assign eoc_ev      = sync_d[2] ^ sync_q[2];
    assign mux_ev      = sync_d[1] ^ sync_q[1];
    assign cfg_ev      = sync_d[0] ^ sync_q[0];

    // Power code of the stored and of the just-arrived word
    assign pm         = {cfg.power_mode_hi, cfg.power_mode_lo};
    assign new_pm     = {next_cfg.power_mode_hi, next_cfg.power_mode_lo};
    assign sweep_code = {cfg_hold.sweep_ctrl_hi, cfg_hold.sweep_ctrl_lo};

    // Decoded power codes of the word now in force
    assign new_full   = (new_pm == `ASC_PM_FULL);
    assign new_auto   = (new_pm == `ASC_PM_AUTO);
    assign new_normal = (new_pm == `ASC_PM_NORMAL);

    // Settings frozen at frame start; this frame's word lands later
    assign frozen_set = {mux_chan, cfg.range_sel, cfg.coding};

    // Twos complement: flip the top bit of the core's straight-binary code
    always_comb begin
        if (conv_set.coding) begin
            coded_data = conv_data;
        end else begin
            coded_data = {~conv_data[`ASC_RES_W-1], conv_data[`ASC_RES_W-2:0]};
        end
    end

    // Configuration, sweep and channel selection
    always_comb begin
        next_cfg         = cfg;
        next_wr_seen     = wr_seen;
        next_sweep_on    = sweep_on;
        next_sweep_start = sweep_start;
        next_sweep_last  = sweep_last;
        next_mux_chan    = mux_chan;
        // The held word is stable for many cycles after its toggle,
        // so the synchronised toggle alone guards the wide read
        if (cfg_ev) begin
            next_cfg     = cfg_hold;
            next_wr_seen = 1'b1;
            if (sweep_code == `ASC_SWEEP_CONT) begin
                next_sweep_on    = 1'b1;
                next_sweep_start = 1'b1;
                next_sweep_last  = {cfg_hold.chan_sel_hi, cfg_hold.chan_sel_lo};
            end else if (!cfg_hold.sweep_ctrl_hi) begin
                next_sweep_on    = 1'b0;
                next_sweep_start = 1'b0;
            end
        end
        // Mux moves on the fourteenth edge, after this frame's word is in
        // A fresh sweep's start flag is read before it is dropped
        if (mux_ev) begin
            if (next_sweep_on) begin
                if (next_sweep_start || mux_chan == next_sweep_last) begin
                    next_mux_chan = 2'h0;
                end else begin
                    next_mux_chan = mux_chan + 2'h1;
                end
            end else begin
                next_mux_chan = {next_cfg.chan_sel_hi, next_cfg.chan_sel_lo};
            end
            next_sweep_start = 1'b0;
        end
        // Frame start opens a fresh write window; a same-cycle write wins
        if (cs_fall && !cfg_ev) begin
            next_wr_seen = 1'b0;
        end
    end

    // Conversion and power state
    always_comb begin
        next_state       = state;
        next_conv_start  = 1'b0;
        next_conv_set    = conv_set;
        next_power_down  = power_down;
        next_result_word = result_word;
        unique case (state)
            st_idle: begin
                if (cs_fall) begin
                    // Settings frozen here, so a word in this frame waits a conversion
                    next_conv_start = 1'b1;
                    next_conv_set   = frozen_set;
                    next_state      = st_conv;
                end
            end
            st_conv: begin
                if (eoc_ev) begin
                    next_result_word.chan = conv_set.chan;
                    next_result_word.data = coded_data;
                    if (new_auto && next_wr_seen) begin
                        next_state      = st_down;
                        next_power_down = 1'b1;
                    end else begin
                        next_state = st_idle;
                    end
                end
            end
            st_down: begin
                // Auto mode wakes on the next frame; full mode waits for a rewrite
                // to normal, while a rewrite to auto waits for the next frame
                if (cs_fall && pm == `ASC_PM_AUTO) begin
                    next_power_down = 1'b0;
                    next_conv_start = 1'b1;
                    next_conv_set   = frozen_set;
                    next_state      = st_conv;
                end else if (new_normal) begin
                    next_power_down = 1'b0;
                    next_state      = st_idle;
                end
            end
            default: begin
                next_state      = st_idle;
                next_power_down = 1'b0;
            end
        endcase
        // Full shutdown overrides everything, stored word is kept
        // Normal code outside the down state clears a stale power-down
        if (new_full) begin
            next_state      = st_down;
            next_power_down = 1'b1;
            next_conv_start = 1'b0;
        end else if (new_normal && state != st_down) begin
            next_power_down = 1'b0;
        end
    end

    // Wake-up timer after any power-down
    // Awake drops on the edge that raises power_down, never one cycle later
    always_comb begin
        next_wake_cnt = wake_cnt;
        next_awake    = awake;
        if (power_down || next_power_down) begin
            next_wake_cnt = '0;
            next_awake    = 1'b0;
        end else if (!awake) begin
            if (wake_cnt == WCW'(WAKE_CYC - 1)) begin
                next_awake = 1'b1;
            end else begin
                next_wake_cnt = wake_cnt + WCW'(1);
            end
        end
    end

    // Register the configuration group
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg         <= `ASC_CFG_RESET;
            wr_seen     <= 1'b0;
            sweep_on    <= 1'b0;
            sweep_start <= 1'b0;
            sweep_last  <= 2'h0;
            mux_chan    <= 2'h0;
            sync_d      <= 4'h0;
        end else begin
            cfg         <= next_cfg;
            wr_seen     <= next_wr_seen;
            sweep_on    <= next_sweep_on;
            sweep_start <= next_sweep_start;
            sweep_last  <= next_sweep_last;
            mux_chan    <= next_mux_chan;
            sync_d      <= next_sync_d;
        end
    end

    // Register the conversion and power group
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state       <= st_idle;
            conv_start  <= 1'b0;
            conv_set    <= '0;
            power_down  <= 1'b0;
            result_word <= '0;
            wake_cnt    <= '0;
            awake       <= 1'b0;
        end else begin
            state       <= next_state;
            conv_start  <= next_conv_start;
            conv_set    <= next_conv_set;
            power_down  <= next_power_down;
            result_word <= next_result_word;
            wake_cnt    <= next_wake_cnt;
            awake       <= next_awake;
        end
    end
endmodule : asc_top
`default_nettype wire

// ---- test/asc_top_assertions.sv ----
// Port checker for asc_top, bound from the bench top file.
// Assumes one clk domain for sampling; link pins are seen as levels.
`timescale 1ns/1ps
`default_nettype none
`include "asc_defs.svh"
module asc_top_assertions #(
    parameter int WAKE_CYC = 2
) (
    input wire logic                  clk,
    input wire logic                  reset_n,
    input wire logic                  sclk,
    input wire logic                  cs_n,
    input wire logic                  din,
    input wire logic [`ASC_RES_W-1:0] conv_data,
    input wire logic                  dout,
    input wire logic                  conv_start,
    input wire asc_pkg::asc_conv_t    conv_set,
    input wire logic [1:0]            mux_chan,
    input wire logic                  power_down,
    input wire logic                  awake
);
    import asc_pkg::*;
    logic [7:0] low_cnt;
    logic [7:0] next_low_cnt;

    // Cycles spent powered up, saturating so long runs cannot wrap
    always_comb begin
        next_low_cnt = power_down ? 8'h00 : ((low_cnt == 8'hff) ? low_cnt : low_cnt + 8'h01);
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            low_cnt <= 8'h00;
        end else begin
            low_cnt <= next_low_cnt;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    chk_start_one_cycle: assert property (conv_start |=> !conv_start)
        else $error("conv_start held longer than one cycle");
    chk_start_in_frame: assert property (conv_start |-> !cs_n && !$past(cs_n))
        else $error("conv_start outside a frame");
    chk_start_follows_cs: assert property ($fell(cs_n) && !power_down |-> ##[1:5] conv_start)
        else $error("no conversion start after chip select fell");
    chk_set_frozen: assert property (!conv_start |-> $stable(conv_set))
        else $error("conv_set moved without a conversion start");
    chk_mux_idle_stable: assert property (cs_n && $past(cs_n, 4) |-> $stable(mux_chan))
        else $error("mux_chan moved between frames");
    chk_dout_idle_low: assert property (cs_n && $past(cs_n) |-> !dout)
        else $error("dout high while deselected");
    chk_pd_idle_stable: assert property (cs_n && $past(cs_n, 6) |-> $stable(power_down))
        else $error("power_down moved between frames");
    chk_awake_after_wait: assert property (awake |-> !power_down && low_cnt >= WAKE_CYC - 1)
        else $error("awake before wake-up time elapsed");
    chk_awake_rises: assert property (!power_down && low_cnt >= WAKE_CYC + 2 |-> awake)
        else $error("awake missing after wake-up time");
    chk_start_wakes: assert property (conv_start |-> ##[0:2] !power_down)
        else $error("converter still down after a start");
endmodule : asc_top_assertions
`default_nettype wire

// ---- test/asc_host_model.sv ----
// Host serial port model: 16-clock frames on cs_n, sclk and din.
// Assumes callers space frames; sclk idles high and stands still between frames.
`timescale 1ns/1ps
`default_nettype none
module asc_host_model (
    output logic      sclk,
    output logic      cs_n,
    output logic      din,
    input  wire logic dout
);
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din  = 1'b1;
    end

    // One frame, 6 ns serial period; callers never send power code 00
    task automatic xfer(input logic [11:0] w, output logic [15:0] rx);
        cs_n = 1'b0;
        din  = w[11];
        #3;
        for (int i = 0; i < 16; i++) begin
            rx   = {rx[14:0], dout};
            sclk = 1'b0;
            #3;
            sclk = 1'b1;
            din  = (i < 11) ? w[10-i] : ~din;
            #3;
        end
        // Long hold lets the clk side read word and result
        #450;
        cs_n = 1'b1;
        din  = ~din; // Released line, no stale level
        #500;
    endtask : xfer
endmodule : asc_host_model
`default_nettype wire

// ---- test/adc_serial_config_word_test.sv ----
// Top bench: frames through the host model, checks at the core-side ports and on the word received from dout.
// Assumes asc_top, the host model and the checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "asc_defs.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module adc_serial_config_word_test;
    import asc_pkg::*;
    localparam int WAKE = 4;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        sclk, cs_n, din, dout, conv_start, power_down, awake;
    logic [11:0] conv_data = 12'h000;
    asc_conv_t   conv_set, last_set;
    logic [1:0]  mux_chan, pc;
    logic [15:0] rx;
    logic [11:0] sw_word [5] = '{12'hfbb, 12'h73b, 12'hf33, 12'h73b, 12'hbf3};
    logic [1:0]  sw_mux [5] = '{2'd0, 2'd1, 2'd2, 2'd0, 2'd3};
    int          n_errors = 0, total_checks = 0, n_start = 0, s;

    always #25 clk = ~clk;

    asc_host_model host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));
    asc_top #(.WAKE_CYC(WAKE)) uut (.clk(clk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n), .din(din),
        .conv_data(conv_data), .dout(dout), .conv_start(conv_start), .conv_set(conv_set),
        .mux_chan(mux_chan), .power_down(power_down), .awake(awake));

    // Count starts and keep the settings handed with each
    always @(negedge clk) begin
        if (conv_start === 1'b1) begin
            n_start++;
            last_set = conv_set;
        end
    end

    // Word layout: unused bits sent as ones to prove they are ignored
    function automatic logic [11:0] word(input logic we, sh, input logic [1:0] ch, pm, input logic sl,
                                         input logic [1:0] rc);
        return {we, sh, 2'b11, ch, pm, sl, 1'b1, rc};
    endfunction : word

    task automatic frame(input logic [11:0] w, input logic [11:0] cd);
        @(negedge clk) conv_data <= cd;
        host.xfer(w, rx);
        @(negedge clk);
    endtask : frame

    task automatic wait_awake;
        for (int k = 0; k < 40 && awake !== 1'b1; k++) @(negedge clk);
        `CHK(awake, 1'b1)
    endtask : wait_awake

    task automatic end_sim;
        if (n_errors == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim

    // Watchdog well past the roughly 20 us of frames
    initial begin
        #200000;
        n_errors++;
        end_sim();
    end

    initial begin
        repeat (6) @(negedge clk);
        reset_n <= 1'b1;
        `CHK({conv_start, conv_set, mux_chan, power_down, awake}, 9'h000)
        wait_awake();
        // New channel and format take effect one conversion later
        frame(word(1, 0, 2'd2, 2'b11, 0, 2'b11), 12'h5a3);
        `CHK(n_start, 1)
        `CHK(last_set, 4'h0)
        `CHK(mux_chan, 2'd2)
        frame(word(0, 0, 2'd1, 2'b11, 0, 2'b00), 12'h3c4);
        `CHK(rx, 16'h0da3)
        `CHK(last_set, 4'hb)
        `CHK(mux_chan, 2'd2)
        frame(word(0, 0, 2'd0, 2'b11, 0, 2'b00), 12'h000);
        `CHK(rx, 16'h23c4)
        // Every channel code, alternating range and coding
        for (int c = 0; c < 4; c++) begin
            pc = last_set.chan;
            frame(word(1, 0, c[1:0], 2'b11, 0, {c[0], ~c[0]}), 12'h800);
            `CHK(mux_chan, c[1:0])
            `CHK(rx[13:12], pc)
            if (c > 0) `CHK(last_set, {2'(c - 1), ~c[0], c[0]})
        end
        // Full shutdown holds across a no-write frame
        frame(word(1, 0, 2'd1, 2'b10, 0, 2'b11), 12'h111);
        `CHK(power_down, 1'b1)
        s = n_start;
        frame(word(0, 0, 2'd1, 2'b11, 0, 2'b11), 12'h111);
        `CHK(n_start, s)
        `CHK(power_down, 1'b1)
        frame(word(1, 0, 2'd1, 2'b11, 0, 2'b11), 12'h111);
        `CHK(power_down, 1'b0)
        wait_awake();
        // Auto shutdown: down after an updating frame, up at next start
        frame(word(1, 0, 2'd1, 2'b01, 0, 2'b11), 12'h111);
        `CHK(power_down, 1'b1)
        s = n_start;
        frame(word(0, 0, 2'd1, 2'b11, 0, 2'b11), 12'h111);
        `CHK(n_start, s + 1)
        `CHK(power_down, 1'b0)
        wait_awake();
        // Sweep to channel 2, continue code, then leave the sweep
        for (int k = 0; k < 5; k++) begin
            frame(sw_word[k], 12'h111);
            `CHK(mux_chan, sw_mux[k])
        end
        end_sim();
    end
endmodule : adc_serial_config_word_test

bind asc_top asc_top_assertions #(.WAKE_CYC(WAKE_CYC)) u_chk (.clk(clk), .reset_n(reset_n), .sclk(sclk),
    .cs_n(cs_n), .din(din), .conv_data(conv_data), .dout(dout), .conv_start(conv_start), .conv_set(conv_set),
    .mux_chan(mux_chan), .power_down(power_down), .awake(awake));
`default_nettype wire
